// [flash_array_model.sv]
// Behavioural flash array that serves start pulses and reads the page buffer.
`timescale 1ns/10ps
`default_nettype none
module flash_array_model #(
    parameter int DELAY = 140
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [15:0] data_i,
    output logic             done_o,
    output logic      [6:0]  idx_o
);
    logic [15:0] mem [128];
    logic [7:0]  cnt_ff;
    logic        busy_ff;
    logic        wr_ff;

    // A page write walks the buffer index; each word arrives one cycle later.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_ff <= 1'b0;
            wr_ff   <= 1'b0;
            cnt_ff  <= 8'h00;
            done_o  <= 1'b0;
            idx_o   <= 7'h00;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_ff <= 1'b1;
                wr_ff   <= write_i;
                cnt_ff  <= 8'h00;
                idx_o   <= 7'h00;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 8'h01;
                idx_o  <= cnt_ff[6:0] + 7'h01;
                if (wr_ff && cnt_ff >= 8'h01 && cnt_ff <= 8'h80) begin
                    mem[cnt_ff - 8'h01] <= data_i;
                end
                if (int'(cnt_ff) == DELAY) begin
                    done_o  <= 1'b1;
                    busy_ff <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [flash_self_program_sequencer.sv]
// Self-programming sequencer for the on-chip program flash.
//
// Summary of operation
// - Temporary buffer words may be loaded in any order.
// - Erase pattern then store within four cycles erases the pointer's page.
// - Erase in halting section halts CPU; concurrent section erase does not.
// - Load pattern then store within four cycles fills one buffer word.
// - Buffer clears after page write, on re-enable and on reset.
// - EEPROM write during loading keeps loaded buffer words.
// - Write pattern then store within four cycles programs the page.
// - Page write in halting section halts CPU; the concurrent section is blocked as well.
// - Enabled interrupt stays high while the operation-enable bit is clear.
// - Erase or write blocks concurrent section; busy flag reads one meanwhile.
// - Software re-enables the section; the device then clears the busy flag.
// - Lock pattern then store within four cycles programs zero data bits 5:0.
// - Lock programming keeps all flash readable with no CPU halt.
// - EEPROM write busy blocks self-programming and fuse, lock, signature reads.
// - Armed lock access plus load within three cycles at 0x0001 returns locks.
// - Armed bits self-clear after read or when the load or store window ends.
// - Armed load returns fuse low at 0, high at 3, extended at 2.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
// - Signature read returns bytes at 0, 2, 4 and calibration at 1.
// - Page index is pointer 16:8, word index is pointer 7:1.
// - Pages from 480 upward form the halting section.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE1 = 8'h11, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE2 = 8'h22, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE3 = 8'h33, // Arbitrary value.
    parameter logic [7:0] CAL_BYTE  = 8'h80
)(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [7:0]  REG_RDATA_O,
    input  wire logic        STORE_I,
    input  wire logic        LOAD_I,
    input  wire logic [16:0] POINTER_I,
    input  wire logic [15:0] DATA_PAIR_I,
    output logic             LOAD_VALID_O,
    output logic      [7:0]  LOAD_DATA_O,
    input  wire logic        EEPROM_WRITE_BUSY_I,
    input  wire logic [7:0]  FUSE_LOW_I,
    input  wire logic [7:0]  FUSE_HIGH_I,
    input  wire logic [2:0]  FUSE_EXT_I,
    input  wire logic [5:0]  LOCK_BITS_I,
    output logic             FLASH_ERASE_O,
    output logic             FLASH_WRITE_O,
    output logic             FLASH_LOCK_O,
    output logic      [8:0]  FLASH_PAGE_O,
    output logic      [5:0]  FLASH_LOCK_DATA_O,
    input  wire logic        FLASH_DONE_I,
    input  wire logic [6:0]  FLASH_BUF_IDX_I,
    output logic      [15:0] FLASH_BUF_DATA_O,
    output logic             CPU_HALT_O,
    output logic             RWW_BLOCK_O,
    output logic             INTR_O
);
    seq_state_t  state_ff;
    logic [5:0]  cmd_ff;
    logic [2:0]  win_ff;
    logic        int_en_ff;
    logic        busy_flag_ff;
    logic [8:0]  page_ff;
    logic [5:0]  lock_data_ff;
    logic        erase_ff;
    logic        write_ff;
    logic        lock_ff;
    logic [7:0]  rdata_ff;
    logic        load_valid_ff;
    logic [7:0]  load_data_ff;
    logic [7:0]  nxt_load_data;
    logic        nxt_load_hit;
    logic        ctrl_wr;
    logic        armed_store;
    logic        armed_load;
    logic        start_op;
    logic        reenable;
    logic        write_done;

    page_buf_if buf_bus ();

    page_word_buffer u_buffer (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .buf_io  (buf_bus.store)
    );

    assign ctrl_wr     = REG_WR_I && REG_ADDR_I == CTRL_OFFSET;
    // A store taken while the EEPROM writes is dropped and disarms the bits.
    assign armed_store = state_ff == ST_ARMED && STORE_I
                         && !EEPROM_WRITE_BUSY_I;
    assign armed_load  = state_ff == ST_ARMED && LOAD_I
                         && win_ff >= LOAD_LAST_WIN
                         && !EEPROM_WRITE_BUSY_I
                         && (cmd_ff == CMD_LOCK || cmd_ff == CMD_SIG);
    assign start_op    = armed_store && (cmd_ff == CMD_ERASE
                         || cmd_ff == CMD_WRITE || cmd_ff == CMD_LOCK);
    assign reenable    = armed_store && cmd_ff == CMD_REENABLE;
    assign write_done  = state_ff == ST_BUSY && FLASH_DONE_I
                         && cmd_ff == CMD_WRITE;

    // Arming, timed windows and the operation in flight.
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= CTRL_RESET[5:0];
            win_ff   <= 3'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (ctrl_wr && REG_WDATA_I[OP_ENABLE_POS]
                        && !EEPROM_WRITE_BUSY_I) begin
                        cmd_ff   <= REG_WDATA_I[5:0];
                        win_ff   <= STORE_WINDOW;
                        state_ff <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    win_ff <= win_ff - 3'h1;
                    if (start_op) begin
                        state_ff <= ST_BUSY;
                    end else if (STORE_I || armed_load
                                 || win_ff == EXPIRE_WIN
                                 || (cmd_ff == CMD_SIG
                                     && win_ff == SIG_EXPIRE_WIN)) begin
                        cmd_ff   <= 6'h00;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    if (FLASH_DONE_I) begin
                        cmd_ff   <= 6'h00;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    cmd_ff   <= 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            int_en_ff <= CTRL_RESET[INT_ENABLE_POS];
        end else if (ctrl_wr) begin
            int_en_ff <= REG_WDATA_I[INT_ENABLE_POS];
        end
    end

    // Set by an erase or write start; a re-enable cannot coincide with one.
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            busy_flag_ff <= 1'b0;
        end else if (start_op && cmd_ff != CMD_LOCK) begin
            busy_flag_ff <= 1'b1;
        end else if (reenable) begin
            busy_flag_ff <= 1'b0;
        end
    end

    // Start strobes toward the flash array; the page is latched at start.
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            erase_ff     <= 1'b0;
            write_ff     <= 1'b0;
            lock_ff      <= 1'b0;
            page_ff      <= 9'h000;
            lock_data_ff <= 6'h3f;
        end else begin
            erase_ff <= start_op && cmd_ff == CMD_ERASE;
            write_ff <= start_op && cmd_ff == CMD_WRITE;
            lock_ff  <= start_op && cmd_ff == CMD_LOCK;
            if (start_op) begin
                page_ff      <= POINTER_I[PAGE_MSB:PAGE_LSB];
                lock_data_ff <= DATA_PAIR_I[5:0];
            end
        end
    end

    assign FLASH_ERASE_O     = erase_ff;
    assign FLASH_WRITE_O     = write_ff;
    assign FLASH_LOCK_O      = lock_ff;
    assign FLASH_PAGE_O      = page_ff;
    assign FLASH_LOCK_DATA_O = lock_data_ff;

    // Only the buffer path and its strobes touch the buffer.
    assign buf_bus.wr      = armed_store && cmd_ff == CMD_LOAD;
    assign buf_bus.wr_idx  = POINTER_I[WORD_MSB:WORD_LSB];
    assign buf_bus.wr_data = DATA_PAIR_I;
    assign buf_bus.clr     = write_done || reenable;
    assign buf_bus.rd_idx  = FLASH_BUF_IDX_I;
    assign FLASH_BUF_DATA_O = buf_bus.rd_data;

    // Halting only for erase or write in the top pages.
    assign CPU_HALT_O  = state_ff == ST_BUSY && cmd_ff != CMD_LOCK
                         && page_ff >= HALTING_SECTION_FIRST_PG;
    assign RWW_BLOCK_O = busy_flag_ff;
    assign INTR_O      = int_en_ff && !cmd_ff[OP_ENABLE_POS];

    // Answers to an armed load; other loads are left to the normal path.
    always_comb begin
        nxt_load_data = 8'hff;
        nxt_load_hit  = armed_load;
        if (cmd_ff == CMD_LOCK) begin
            unique case (POINTER_I)
                PTR_FUSE_LOW:  nxt_load_data = FUSE_LOW_I;
                PTR_LOCK:      nxt_load_data = {LOCK_PAD, LOCK_BITS_I};
                PTR_FUSE_EXT:  nxt_load_data = {EXT_PAD, FUSE_EXT_I};
                PTR_FUSE_HIGH: nxt_load_data = FUSE_HIGH_I;
                default:       nxt_load_hit  = 1'b0;
            endcase
        end else begin
            unique case (POINTER_I)
                PTR_SIG1: nxt_load_data = SIG_BYTE1;
                PTR_CAL:  nxt_load_data = CAL_BYTE;
                PTR_SIG2: nxt_load_data = SIG_BYTE2;
                PTR_SIG3: nxt_load_data = SIG_BYTE3;
                default:  nxt_load_hit  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            load_valid_ff <= 1'b0;
            load_data_ff  <= 8'h00;
        end else begin
            load_valid_ff <= nxt_load_hit;
            if (nxt_load_hit) begin
                load_data_ff <= nxt_load_data;
            end
        end
    end

    assign LOAD_VALID_O = load_valid_ff;
    assign LOAD_DATA_O  = load_data_ff;

    // Register read port; unmapped addresses read zero.
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_ff <= 8'h00;
        end else if (REG_RD_I && REG_ADDR_I == CTRL_OFFSET) begin
            rdata_ff <= {int_en_ff, busy_flag_ff, cmd_ff};
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign REG_RDATA_O = rdata_ff;

    // Arming window, start strobes and the EEPROM interlock.
    a_erase_start: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        armed_store && cmd_ff == CMD_ERASE
        |=> FLASH_ERASE_O ##1 !FLASH_ERASE_O)
        else $error("erase not started after armed store");
    a_store_window: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_IDLE && ctrl_wr && REG_WDATA_I[OP_ENABLE_POS]
        && !EEPROM_WRITE_BUSY_I && !STORE_I && !LOAD_I
        ##1 (!STORE_I && !REG_WR_I)[*4]
        |=> state_ff == ST_IDLE)
        else $error("arming did not expire after four cycles");
    a_sig_expire: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_ARMED && cmd_ff == CMD_SIG
        && win_ff == SIG_EXPIRE_WIN |=> state_ff == ST_IDLE)
        else $error("signature arming did not expire");
    a_load_pulse: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        LOAD_VALID_O |=> !LOAD_VALID_O)
        else $error("armed load served twice");
    a_ee_blocks: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_IDLE && EEPROM_WRITE_BUSY_I |=> state_ff == ST_IDLE)
        else $error("arming accepted during EEPROM write");
    a_ee_no_start: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_ARMED && EEPROM_WRITE_BUSY_I |=> state_ff != ST_BUSY)
        else $error("operation started during EEPROM write");
    a_page_latch: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        start_op |=> FLASH_PAGE_O == $past(POINTER_I[PAGE_MSB:PAGE_LSB]))
        else $error("page index not latched at start");

    // Section busy flag, halting and the interrupt level.
    a_busy_flag_set: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        $rose(FLASH_WRITE_O) || $rose(FLASH_ERASE_O) |-> RWW_BLOCK_O)
        else $error("busy flag not set at page erase or write");
    a_busy_hold: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        RWW_BLOCK_O && !reenable |=> RWW_BLOCK_O)
        else $error("busy flag dropped without re-enable");
    a_reenable_clear: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        reenable |=> !RWW_BLOCK_O)
        else $error("busy flag not cleared by re-enable");
    a_op_enable_hold: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_BUSY |-> cmd_ff[OP_ENABLE_POS] && !INTR_O)
        else $error("operation enable dropped while busy");
    a_intr_level: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        int_en_ff && state_ff == ST_IDLE |-> INTR_O)
        else $error("interrupt not asserted while idle and enabled");
    a_intr_armed: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        state_ff == ST_ARMED |-> !INTR_O)
        else $error("interrupt asserted while armed");
    a_halt_section: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        CPU_HALT_O |-> page_ff >= HALTING_SECTION_FIRST_PG && cmd_ff != CMD_LOCK)
        else $error("CPU halted outside halting section");
    a_halt_entry: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        start_op && cmd_ff != CMD_LOCK
        && POINTER_I[PAGE_MSB:PAGE_LSB] >= HALTING_SECTION_FIRST_PG |=> CPU_HALT_O)
        else $error("CPU not halted for halting section");
    a_lock_no_halt: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        FLASH_LOCK_O |-> !CPU_HALT_O)
        else $error("CPU halted during lock programming");

    // Armed reads of the lock bits.
    a_lock_read: assert property (
        @(posedge CLOCK_I) disable iff (!RST_N_I)
        armed_load && cmd_ff == CMD_LOCK && POINTER_I == PTR_LOCK
        |=> LOAD_VALID_O && LOAD_DATA_O == {LOCK_PAD, $past(LOCK_BITS_I)})
        else $error("lock bits not returned");
endmodule
`default_nettype wire

// [flash_seq_pkg.sv]
// Constants, field layouts and state types of the self-programming sequencer.
package flash_seq_pkg;
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int          OP_ENABLE_POS  = 0;
    localparam int          SEC_BUSY_POS   = 6;
    localparam int          INT_ENABLE_POS = 7;
    localparam logic [5:0]  CMD_ERASE      = 6'h03;
    localparam logic [5:0]  CMD_LOAD       = 6'h01;
    localparam logic [5:0]  CMD_WRITE      = 6'h05;
    localparam logic [5:0]  CMD_LOCK       = 6'h09;
    localparam logic [5:0]  CMD_REENABLE   = 6'h11;
    localparam logic [5:0]  CMD_SIG        = 6'h21;
    localparam logic [2:0]  STORE_WINDOW   = 3'h4;
    localparam logic [2:0]  LOAD_LAST_WIN  = 3'h2;
    localparam logic [2:0]  SIG_EXPIRE_WIN = 3'h2;
    localparam logic [2:0]  EXPIRE_WIN     = 3'h1;
    localparam int          PAGE_MSB       = 16;
    localparam int          PAGE_LSB       = 8;
    localparam int          WORD_MSB       = 7;
    localparam int          WORD_LSB       = 1;
    localparam int          WORDS          = 128;
    localparam logic [8:0]  HALTING_SECTION_FIRST_PG  = 9'h1e0;
    localparam logic [16:0] PTR_FUSE_LOW   = 17'h00000;
    localparam logic [16:0] PTR_LOCK       = 17'h00001;
    localparam logic [16:0] PTR_FUSE_EXT   = 17'h00002;
    localparam logic [16:0] PTR_FUSE_HIGH  = 17'h00003;
    localparam logic [16:0] PTR_SIG1       = 17'h00000;
    localparam logic [16:0] PTR_CAL        = 17'h00001;
    localparam logic [16:0] PTR_SIG2       = 17'h00002;
    localparam logic [16:0] PTR_SIG3       = 17'h00004;
    localparam logic [1:0]  LOCK_PAD       = 2'h3;
    localparam logic [4:0]  EXT_PAD        = 5'h1f;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_BUSY  = 2'b10
    } seq_state_t;
endpackage

// [page_buf_if.sv]
// Interface between the sequencer and its temporary page buffer.
`timescale 1ns/10ps
`default_nettype none
interface page_buf_if;
    logic        wr;
    logic        clr;
    logic [6:0]  wr_idx;
    logic [15:0] wr_data;
    logic [6:0]  rd_idx;
    logic [15:0] rd_data;
    modport ctrl  (output wr, clr, wr_idx, wr_data, rd_idx, input rd_data);
    modport store (input wr, clr, wr_idx, wr_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

// [page_word_buffer.sv]
// Temporary page buffer of 128 words held in flip-flops.
`timescale 1ns/10ps
`default_nettype none
module page_word_buffer
    import flash_seq_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    page_buf_if.store  buf_io
);
    logic [15:0] word_ff [WORDS];
    logic [15:0] rd_ff;

    // Words are written at any index in any order; clear wins over write.
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                word_ff[i] <= 16'hffff;
            end else if (buf_io.clr) begin
                word_ff[i] <= 16'hffff;
            end else if (buf_io.wr && buf_io.wr_idx == 7'(i)) begin
                word_ff[i] <= buf_io.wr_data;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ff <= 16'hffff;
        end else begin
            rd_ff <= word_ff[buf_io.rd_idx];
        end
    end
    assign buf_io.rd_data = rd_ff;

    a_clear_erases: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        buf_io.clr |=> word_ff[0] == 16'hffff)
        else $error("page buffer not cleared");
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the flash self-programming sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb
    import flash_seq_pkg::*;
;
    typedef struct {
        logic [7:0]  c;
        logic [16:0] p;
        int          g;
        logic [7:0]  e;
    } row_t;
    localparam logic [7:0] FL = 8'h62;
    localparam logic [7:0] FH = 8'h99;
    localparam logic [2:0] FE = 3'h5;
    localparam logic [5:0] LK = 6'h2a;
    // Signature and calibration bytes are arbitrary values.
    localparam logic [7:0] S1 = 8'h5a;
    localparam logic [7:0] S2 = 8'h6b;
    localparam logic [7:0] S3 = 8'h7c;
    localparam logic [7:0] CB = 8'h9d;
    logic        clk, rst_n, wr, rd, store, load, ee_busy, lvalid, done;
    logic        erase_p, write_p, lock_p, halt, block, intr;
    logic [7:0]  addr, wdata, rdata, ldata, v;
    logic [16:0] ptr;
    logic [15:0] dpair, bdata;
    logic [8:0]  page;
    logic [5:0]  lock_data;
    logic [6:0]  bidx;
    int          failures, n_tests, cycles;
    row_t        rows [8] = '{
        '{8'h09, 17'h1, 1, {2'b11, LK}}, '{8'h09, 17'h0, 2, FL},
        '{8'h09, 17'h3, 3, FH}, '{8'h09, 17'h2, 1, {5'h1f, FE}},
        '{8'h21, 17'h0, 1, S1}, '{8'h21, 17'h1, 2, CB},
        '{8'h21, 17'h2, 3, S2}, '{8'h21, 17'h4, 1, S3}};

    flash_self_program_sequencer #(
        .SIG_BYTE1(S1), .SIG_BYTE2(S2), .SIG_BYTE3(S3), .CAL_BYTE(CB)
    ) flash_self_program_sequencer_i (
        .CLOCK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .STORE_I(store), .LOAD_I(load),
        .POINTER_I(ptr), .DATA_PAIR_I(dpair), .LOAD_VALID_O(lvalid),
        .LOAD_DATA_O(ldata), .EEPROM_WRITE_BUSY_I(ee_busy),
        .FUSE_LOW_I(FL), .FUSE_HIGH_I(FH), .FUSE_EXT_I(FE),
        .LOCK_BITS_I(LK), .FLASH_ERASE_O(erase_p), .FLASH_WRITE_O(write_p),
        .FLASH_LOCK_O(lock_p), .FLASH_PAGE_O(page),
        .FLASH_LOCK_DATA_O(lock_data), .FLASH_DONE_I(done),
        .FLASH_BUF_IDX_I(bidx), .FLASH_BUF_DATA_O(bdata),
        .CPU_HALT_O(halt), .RWW_BLOCK_O(block), .INTR_O(intr));

    flash_array_model #(.DELAY(140)) flash_array_model_i (
        .clk_i(clk), .rst_n_i(rst_n), .start_i(erase_p | write_p | lock_p),
        .write_i(write_p), .data_i(bdata), .done_o(done), .idx_o(bidx));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= 8'h00;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Arms a command and issues a store or load in cycle g after the write.
    task automatic cmd(input logic [7:0] c, input int g, input logic ld,
                       input logic [16:0] p, input logic [15:0] d);
        dpair <= d;
        wreg(c);
        repeat (g - 1) @(posedge clk);
        ptr <= p;
        if (ld)
            load <= 1'b1;
        else
            store <= 1'b1;
        @(posedge clk);
        load  <= 1'b0;
        store <= 1'b0;
        #1;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1)
                break;
        end
        chk("done_seen", 16'(i < 300), 16'h1);
        @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        {rst_n, wr, rd, store, load, ee_busy} = '0;
        {addr, wdata, ptr, dpair} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rreg(8'h00);
        chk("ctrl_reset", 16'(v), 16'(CTRL_RESET));
        chk("intr_reset", 16'(intr), 16'h0);
        chk("buf_reset", bdata, 16'hffff);
        rreg(8'h01);
        chk("unmapped", 16'(v), 16'h0);
        $display("reset test done");
        foreach (rows[k]) begin
            cmd(rows[k].c, rows[k].g, 1'b1, rows[k].p, 16'h0);
            chk("load_valid", 16'(lvalid), 16'h1);
            chk("load_data", 16'(ldata), 16'(rows[k].e));
            rreg(8'h00);
            chk("self_clear", 16'(v[0]), 16'h0);
        end
        $display("armed read table done");
        cmd(8'h09, 4, 1'b1, 17'h1, 16'h0);
        chk("late_load", 16'(lvalid), 16'h0);
        rreg(8'h00);
        chk("expired", 16'(v[0]), 16'h0);
        cmd(8'h03, 5, 1'b0, 17'h0, 16'h0);
        chk("late_store", 16'(erase_p), 16'h0);
        ee_busy <= 1'b1;
        cmd(8'h09, 1, 1'b1, 17'h1, 16'h0);
        chk("ee_load", 16'(lvalid), 16'h0);
        cmd(8'h03, 1, 1'b0, 17'h0, 16'h0);
        chk("ee_erase", 16'(erase_p), 16'h0);
        ee_busy <= 1'b0;
        $display("window and eeprom test done");
        // Erase and write use the same page.
        cmd(8'h03, 4, 1'b0, {9'h1e0, 8'h0e}, 16'h1234);
        chk("erase", 16'({erase_p, halt, block}), 16'h7);
        chk("erase_page", 16'(page), 16'h1e0);
        rreg(8'h00);
        chk("busy_bits", 16'({v[6], v[0]}), 16'h3);
        wait_done();
        chk("erase_end", 16'({halt, block}), 16'h1);
        cmd(8'h11, 1, 1'b0, 17'h0, 16'h0);
        chk("reenable", 16'(block), 16'h0);
        // Words loaded once each, out of order.
        cmd(8'h01, 2, 1'b0, {9'h1e0, 7'd5, 1'b0}, 16'hbeef);
        ee_busy <= 1'b1;
        repeat (3) @(posedge clk);
        ee_busy <= 1'b0;
        cmd(8'h01, 1, 1'b0, {9'h1e0, 7'd2, 1'b0}, 16'hc0de);
        cmd(8'h85, 1, 1'b0, {9'h1e0, 8'h00}, 16'h0);
        chk("write", 16'({write_p, halt, block, intr}), 16'he);
        chk("write_page", 16'(page), 16'h1e0);
        wait_done();
        chk("word5", flash_array_model_i.mem[5], 16'hbeef);
        chk("word2", flash_array_model_i.mem[2], 16'hc0de);
        chk("word0", flash_array_model_i.mem[0], 16'hffff);
        chk("intr_done", 16'({intr, halt}), 16'h2);
        $display("erase and write test done");
        cmd(8'h01, 1, 1'b0, {9'h010, 7'd5, 1'b0}, 16'h1111);
        cmd(8'h11, 1, 1'b0, 17'h0, 16'h0);
        chk("intr_off", 16'(intr), 16'h0);
        cmd(8'h05, 3, 1'b0, {9'h010, 8'h00}, 16'h0);
        chk("rww_write", 16'({write_p, halt, block}), 16'h5);
        wait_done();
        chk("clr_word5", flash_array_model_i.mem[5], 16'hffff);
        chk("clr_word2", flash_array_model_i.mem[2], 16'hffff);
        cmd(8'h11, 1, 1'b0, 17'h0, 16'h0);
        // Lock pointer and data bits 7:6 as recommended.
        cmd(8'h09, 1, 1'b0, 17'h1, 16'hffc5);
        chk("lock", 16'({lock_p, halt, block}), 16'h4);
        chk("lock_data", 16'(lock_data), 16'h05);
        rreg(8'h00);
        chk("lock_busy", 16'(v[0]), 16'h1);
        wait_done();
        rreg(8'h00);
        chk("lock_end", 16'(v[0]), 16'h0);
        $display("lock test done");
        // A reset in mid-run must drop a loaded buffer word.
        cmd(8'h01, 1, 1'b0, {9'h010, 7'd3, 1'b0}, 16'haaaa);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_outs", 16'({block, halt, intr, lvalid}), 16'h0);
        cmd(8'h05, 1, 1'b0, {9'h010, 8'h00}, 16'h0);
        wait_done();
        chk("rst_word3", flash_array_model_i.mem[3], 16'hffff);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
`default_nettype wire
